// [verilog/cra_pkg.sv]
// Shared constants for the converter register access block
package cra_pkg;

    // ------------------------------------------------------------
    // Bus word offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_COMMAND = 8'h00;
    localparam logic [7:0] OFS_TRANSFER = 8'h04;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [7:0] OFS_SEQ_STATE = 8'h10;

    // ------------------------------------------------------------
    // Access command layout
    // ------------------------------------------------------------
    localparam int CMD_GATE_BIT = 7;
    localparam int CMD_DIR_BIT = 6;
    localparam int CMD_SEL_MSB = 3;
    localparam logic [3:0] SEL_STATUS = 4'h0;
    localparam logic [3:0] SEL_MODE = 4'h1;
    localparam logic [3:0] SEL_MAIN = 4'h2;
    localparam logic [3:0] SEL_FILTER = 4'h3;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] MAIN_RESET = 8'h07;
    localparam logic [7:0] FILTER_RESET = 8'h45;
    localparam logic [7:0] MODE_WMASK = 8'h5f;
    localparam int ST_LOCK_BIT = 0;
    localparam int ST_ZERO_BIT = 1;
    localparam int MODE_AMP_BIT = 6;
    localparam int MODE_PAIR_BIT = 4;
    localparam int MODE_OSC_BIT = 3;
    localparam int MAIN_EN_BIT = 7;
    localparam int MAIN_WIDTH_BIT = 6;
    localparam int MAIN_UB_BIT = 3;

    // ------------------------------------------------------------
    // Bus responses and sequencer states
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic {
        SEQ_EXPECT_CMD = 1'b0,
        SEQ_EXPECT_XFER = 1'b1
    } cra_seq_e;

endpackage : cra_pkg

// [verilog/cra_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module cra_pin_sync #(
    parameter int WIDTH = 2
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            // Output moves only once stages two and three agree
            always_ff @(posedge mclk or posedge sys_rst) begin
                if (sys_rst) begin
                    stage1_reg[i] <= 1'b0;
                    stage2_reg[i] <= 1'b0;
                    stage3_reg[i] <= 1'b0;
                    pinOut[i] <= 1'b0;
                end else begin
                    stage1_reg[i] <= pinIn[i];
                    stage2_reg[i] <= stage1_reg[i];
                    stage3_reg[i] <= stage2_reg[i];
                    if (stage2_reg[i] == stage3_reg[i]) begin
                        pinOut[i] <= stage3_reg[i];
                    end
                end
            end
        end
    endgenerate

endmodule : cra_pin_sync

// [verilog/cra_event_flags.sv]
// Sticky event flags with mask and level interrupt
`timescale 1ns/100ps
module cra_event_flags #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] levels,
    input wire logic [WIDTH-1:0] clearBits,
    input wire logic maskWrite,
    input wire logic [WIDTH-1:0] maskData,
    output logic [WIDTH-1:0] pending,
    output logic [WIDTH-1:0] mask,
    output logic irq
);

    logic [WIDTH-1:0] levelPrev_reg;
    logic [WIDTH-1:0] pending_next;
    logic [WIDTH-1:0] mask_next;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
            // Rising edge sets; a set in the clearing cycle wins
            assign pending_next[i] = (levels[i] & ~levelPrev_reg[i]) | (pending[i] & ~clearBits[i]);
        end
    endgenerate

    assign mask_next = maskWrite ? maskData : mask;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            levelPrev_reg <= '0;
            pending <= '0;
            mask <= '0;
            irq <= 1'b0;
        end else begin
            levelPrev_reg <= levels;
            pending <= pending_next;
            mask <= mask_next;
            irq <= |(pending_next & mask_next);
        end
    end

endmodule : cra_event_flags

// [verilog/cra_converter_register_access.sv]
// Converter register bank behind an AXI4-Lite slave
`timescale 1ns/100ps
module cra_converter_register_access #(
    parameter int ADDR_W = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic mainResultReady,
    input wire logic auxResultReady,
    input wire logic calibrationBusy,
    input wire logic mainChannelFault,
    input wire logic auxChannelFault,
    input wire logic missingReferencePin,
    input wire logic pllLockPin,
    output logic [7:0] operatingSetup,
    output logic [7:0] mainConverterSetup,
    output logic [7:0] decimationWord,
    output logic irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic awHeld_reg;
    logic [ADDR_W-1:0] awAddr_reg;
    logic wHeld_reg;
    logic [31:0] wData_reg;
    logic wStrb0_reg;
    logic [7:0] command_reg;
    cra_pkg::cra_seq_e seq_reg;
    cra_pkg::cra_seq_e seq_next;

    // ------------------------------------------------------------
    // Pin inputs and status byte
    // ------------------------------------------------------------
    logic [1:0] pinSync;
    logic missingReferenceFlag;
    logic pllSettled;
    logic [7:0] statusFlags;

    cra_pin_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pinIn({missingReferencePin, pllLockPin}),
        .pinOut(pinSync)
    );

    assign missingReferenceFlag = pinSync[1];
    assign pllSettled = pinSync[0];
    // status layout, bit one fixed zero
    assign statusFlags = {mainResultReady, auxResultReady, calibrationBusy, missingReferenceFlag,
                          mainChannelFault, auxChannelFault, 1'b0, pllSettled};

    // ------------------------------------------------------------
    // Write channel decode
    // ------------------------------------------------------------
    logic awFire;
    logic wFire;
    logic doWrite;
    logic [7:0] wByte;
    logic hitCmdW;
    logic hitXferW;
    logic hitIrqStatW;
    logic hitIrqMaskW;
    logic mappedW;
    logic cmdAccept;
    logic xferWrite;
    logic xferWriteBad;
    logic [3:0] targetSel;
    logic dirIsRead;
    logic bvalidNext;
    logic awHeldNext;
    logic wHeldNext;

    assign awFire = s_axi_awvalid & s_axi_awready;
    assign wFire = s_axi_wvalid & s_axi_wready;
    assign doWrite = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
    assign wByte = wData_reg[7:0];
    assign hitCmdW = awAddr_reg[7:0] == cra_pkg::OFS_COMMAND;
    assign hitXferW = awAddr_reg[7:0] == cra_pkg::OFS_TRANSFER;
    assign hitIrqStatW = awAddr_reg[7:0] == cra_pkg::OFS_IRQ_STATUS;
    assign hitIrqMaskW = awAddr_reg[7:0] == cra_pkg::OFS_IRQ_MASK;
    assign mappedW = hitCmdW | hitXferW | hitIrqStatW | hitIrqMaskW;
    // target select and direction of the pending transfer
    assign targetSel = command_reg[cra_pkg::CMD_SEL_MSB:0];
    assign dirIsRead = command_reg[cra_pkg::CMD_DIR_BIT];
    // command taken only while the gate bit is cleared
    assign cmdAccept = doWrite & hitCmdW & wStrb0_reg & ~wByte[cra_pkg::CMD_GATE_BIT];
    // a transfer needs a command opening it in the write direction
    assign xferWrite = doWrite & hitXferW & (seq_reg == cra_pkg::SEQ_EXPECT_XFER) & ~dirIsRead;
    assign xferWriteBad = doWrite & hitXferW & ~xferWrite;

    assign awHeldNext = (awHeld_reg | awFire) & ~doWrite;
    assign wHeldNext = (wHeld_reg | wFire) & ~doWrite;
    assign bvalidNext = doWrite | (s_axi_bvalid & ~s_axi_bready);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            awHeld_reg <= 1'b0;
            awAddr_reg <= '0;
            wHeld_reg <= 1'b0;
            wData_reg <= '0;
            wStrb0_reg <= 1'b0;
        end else begin
            awHeld_reg <= awHeldNext;
            wHeld_reg <= wHeldNext;
            if (awFire) begin
                awAddr_reg <= s_axi_awaddr;
            end
            if (wFire) begin
                wData_reg <= s_axi_wdata;
                wStrb0_reg <= s_axi_wstrb[0];
            end
        end
    end

    // One write in flight; ready drops until the response is taken
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= cra_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= ~awHeldNext & ~bvalidNext;
            s_axi_wready <= ~wHeldNext & ~bvalidNext;
            s_axi_bvalid <= bvalidNext;
            if (doWrite) begin
                s_axi_bresp <= (mappedW & ~xferWriteBad) ? cra_pkg::RESP_OKAY : cra_pkg::RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------
    // Read channel decode
    // ------------------------------------------------------------
    logic arFire;
    logic rvalidNext;
    logic hitCmdR;
    logic hitXferR;
    logic hitIrqStatR;
    logic hitIrqMaskR;
    logic hitSeqR;
    logic xferRead;
    logic mappedR;
    logic [7:0] targetValue;
    logic [7:0] readByte;
    logic [7:0] irqPending;
    logic [7:0] irqMask;

    assign arFire = s_axi_arvalid & s_axi_arready;
    assign rvalidNext = arFire | (s_axi_rvalid & ~s_axi_rready);
    assign hitCmdR = s_axi_araddr[7:0] == cra_pkg::OFS_COMMAND;
    assign hitXferR = s_axi_araddr[7:0] == cra_pkg::OFS_TRANSFER;
    assign hitIrqStatR = s_axi_araddr[7:0] == cra_pkg::OFS_IRQ_STATUS;
    assign hitIrqMaskR = s_axi_araddr[7:0] == cra_pkg::OFS_IRQ_MASK;
    assign hitSeqR = s_axi_araddr[7:0] == cra_pkg::OFS_SEQ_STATE;
    // read transfer only after a read command
    assign xferRead = arFire & hitXferR & (seq_reg == cra_pkg::SEQ_EXPECT_XFER) & dirIsRead;
    assign mappedR = hitCmdR | (hitXferR & xferRead) | hitIrqStatR | hitIrqMaskR | hitSeqR;

    // selected register onto the transfer word
    assign targetValue = (targetSel == cra_pkg::SEL_STATUS) ? statusFlags :
                         (targetSel == cra_pkg::SEL_MODE) ? operatingSetup :
                         (targetSel == cra_pkg::SEL_MAIN) ? mainConverterSetup :
                         (targetSel == cra_pkg::SEL_FILTER) ? decimationWord : 8'h00;

    // Command reads as zero since it is write-only
    assign readByte = xferRead ? targetValue :
                      hitIrqStatR ? irqPending :
                      hitIrqMaskR ? irqMask :
                      hitSeqR ? {6'h00, dirIsRead, seq_reg == cra_pkg::SEQ_EXPECT_XFER} : 8'h00;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= cra_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= ~rvalidNext;
            s_axi_rvalid <= rvalidNext;
            if (arFire) begin
                s_axi_rdata <= {24'h000000, readByte};
                s_axi_rresp <= mappedR ? cra_pkg::RESP_OKAY : cra_pkg::RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    // back to expecting a command after the one transfer
    assign seq_next = cmdAccept ? cra_pkg::SEQ_EXPECT_XFER :
                      (xferWrite | xferRead) ? cra_pkg::SEQ_EXPECT_CMD : seq_reg;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            seq_reg <= cra_pkg::SEQ_EXPECT_CMD;
            command_reg <= cra_pkg::CMD_RESET;
        end else begin
            seq_reg <= seq_next;
            if (cmdAccept) begin
                command_reg <= wByte;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic xferWrByte;
    assign xferWrByte = xferWrite & wStrb0_reg;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            operatingSetup <= cra_pkg::MODE_RESET;
            mainConverterSetup <= cra_pkg::MAIN_RESET;
            decimationWord <= cra_pkg::FILTER_RESET;
        end else begin
            if (xferWrByte && targetSel == cra_pkg::SEL_MODE) begin
                operatingSetup <= wByte & cra_pkg::MODE_WMASK;
            end
            if (xferWrByte && targetSel == cra_pkg::SEL_MAIN) begin
                mainConverterSetup <= wByte;
            end
            // one decimation word for both converters
            if (xferWrByte && targetSel == cra_pkg::SEL_FILTER) begin
                decimationWord <= wByte;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupts on rising status flags
    // ------------------------------------------------------------
    logic [7:0] irqClear;
    logic irqMaskWrite;
    assign irqClear = (doWrite & hitIrqStatW & wStrb0_reg) ? wByte : 8'h00;
    assign irqMaskWrite = doWrite & hitIrqMaskW & wStrb0_reg;

    cra_event_flags #(
        .WIDTH(8)
    ) u_event_flags (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .levels(statusFlags),
        .clearBits(irqClear),
        .maskWrite(irqMaskWrite),
        .maskData(wByte),
        .pending(irqPending),
        .mask(irqMask),
        .irq(irq)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_cmd_select;
        @(posedge mclk) disable iff (sys_rst)
        cmdAccept |=> (seq_reg == cra_pkg::SEQ_EXPECT_XFER) && (targetSel == $past(wByte[3:0]));
    endproperty
    a_cmd_select: assert property (p_cmd_select) else $error("command select not latched");

    property p_gate_block;
        @(posedge mclk) disable iff (sys_rst)
        (doWrite && hitCmdW && wByte[cra_pkg::CMD_GATE_BIT]) |=> $stable(command_reg);
    endproperty
    a_gate_block: assert property (p_gate_block) else $error("gated command altered state");

    property p_status_read;
        @(posedge mclk) disable iff (sys_rst)
        (xferRead && targetSel == cra_pkg::SEL_STATUS) |=>
            s_axi_rvalid && s_axi_rdata[7:0] == $past(statusFlags) && !s_axi_rdata[cra_pkg::ST_ZERO_BIT];
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read mismatch");

    property p_mode_reserved;
        @(posedge mclk) disable iff (sys_rst)
        (operatingSetup & ~cra_pkg::MODE_WMASK) == 8'h00;
    endproperty
    a_mode_reserved: assert property (p_mode_reserved) else $error("mode zero bit set");

    property p_main_reset;
        @(posedge mclk) disable iff (sys_rst)
        $past(sys_rst) |-> mainConverterSetup == cra_pkg::MAIN_RESET && decimationWord == cra_pkg::FILTER_RESET;
    endproperty
    a_main_reset: assert property (p_main_reset) else $error("setup reset value wrong");

    property p_filter_write;
        @(posedge mclk) disable iff (sys_rst)
        (xferWrByte && targetSel == cra_pkg::SEL_FILTER) |=> decimationWord == $past(wByte);
    endproperty
    a_filter_write: assert property (p_filter_write) else $error("decimation word not written");

    property p_main_write;
        @(posedge mclk) disable iff (sys_rst)
        (xferWrByte && targetSel == cra_pkg::SEL_MAIN) |=> mainConverterSetup == $past(wByte) && s_axi_bvalid;
    endproperty
    a_main_write: assert property (p_main_write) else $error("main setup write lost");

    property p_return_cmd;
        @(posedge mclk) disable iff (sys_rst)
        (xferWrite || xferRead) |=> seq_reg == cra_pkg::SEQ_EXPECT_CMD [*2] or cmdAccept;
    endproperty
    a_return_cmd: assert property (p_return_cmd) else $error("sequencer did not return");

    property p_unopened_xfer;
        @(posedge mclk) disable iff (sys_rst)
        xferWriteBad |=> s_axi_bvalid && s_axi_bresp == cra_pkg::RESP_SLVERR && $stable(decimationWord);
    endproperty
    a_unopened_xfer: assert property (p_unopened_xfer) else $error("unopened transfer accepted");

endmodule : cra_converter_register_access

// [dv/cra_conv_model.sv]
// Behavioural converter core feeding the status levels
`timescale 1ns/100ps
module cra_conv_model (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [6:0] want,
    output logic mainResultReady,
    output logic auxResultReady,
    output logic calibrationBusy,
    output logic mainChannelFault,
    output logic auxChannelFault,
    output logic missingReferencePin,
    output logic pllLockPin
);
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            {mainResultReady, auxResultReady, calibrationBusy} <= 3'h0;
            {mainChannelFault, auxChannelFault} <= 2'h0;
        end else begin
            {mainResultReady, auxResultReady, calibrationBusy} <= want[6:4];
            {mainChannelFault, auxChannelFault} <= want[2:1];
        end
    end
    // Analog pins move off the clock edge, as a real detector would
    always @(posedge mclk) begin
        #9 {missingReferencePin, pllLockPin} = {want[3], want[0]};
    end
endmodule : cra_conv_model

// [dv/tb.sv]
// Self-checking bench for the converter register access block
`timescale 1ns/100ps
module tb;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0] operatingSetup, mainConverterSetup, decimationWord;
    logic mainResultReady, auxResultReady, calibrationBusy, mainChannelFault, auxChannelFault;
    logic missingReferencePin, pllLockPin;
    logic [6:0] want = 7'h00;
    logic [31:0] seed = 32'h0000a97f;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    int errorCnt = 0, nChecks = 0, cyc = 0;

    cra_converter_register_access #(.ADDR_W(8)) cra_converter_register_access_i (
        .mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .mainResultReady(mainResultReady), .auxResultReady(auxResultReady), .calibrationBusy(calibrationBusy),
        .mainChannelFault(mainChannelFault), .auxChannelFault(auxChannelFault),
        .missingReferencePin(missingReferencePin), .pllLockPin(pllLockPin), .operatingSetup(operatingSetup),
        .mainConverterSetup(mainConverterSetup), .decimationWord(decimationWord), .irq(irq));

    cra_conv_model cra_conv_model_i (
        .mclk(mclk), .sys_rst(sys_rst), .want(want), .mainResultReady(mainResultReady),
        .auxResultReady(auxResultReady), .calibrationBusy(calibrationBusy), .mainChannelFault(mainChannelFault),
        .auxChannelFault(auxChannelFault), .missingReferencePin(missingReferencePin), .pllLockPin(pllLockPin));

    initial forever #12.5 mclk = ~mclk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic conclude();
        $display("checks %0d errors %0d", nChecks, errorCnt);
        if (errorCnt == 0 && nChecks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    task automatic chkRd(input logic [33:0] got, input logic [33:0] exp);
        nChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED %0t read got %h exp %h", $time, got, exp);
        end
    endtask : chkRd

    task automatic chkWr(input logic [1:0] got, input logic [1:0] exp);
        nChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED %0t bresp got %h exp %h", $time, got, exp);
        end
    endtask : chkWr

    task automatic chkOut(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED %0t output got %h exp %h", $time, got, exp);
        end
    endtask : chkOut

    // Both channels offered together, each released when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic awDone, wDone;
        @(posedge mclk);
        bq.push_back(er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        awDone = 1'b0;
        wDone = 1'b0;
        while (!(awDone && wDone)) begin
            @(posedge mclk);
            if (!awDone && s_axi_awready === 1'b1) begin
                awDone = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wDone && s_axi_wready === 1'b1) begin
                wDone = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge mclk);
        rq.push_back({er, ed});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge mclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask : axr

    // Oldest note is matched against each response
    always @(posedge mclk) begin
        if (s_axi_bvalid === 1'b1 && s_axi_bready) chkWr(s_axi_bresp, bq.size() ? bq.pop_front() : 2'bxx);
        if (s_axi_rvalid === 1'b1 && s_axi_rready) chkRd({s_axi_rresp, s_axi_rdata}, rq.size() ? rq.pop_front() : 'x);
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            errorCnt++;
            $display("CHECK FAILED %0t timeout", $time);
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        logic [31:0] v, rstVals, wMask, setups;
        logic [7:0] s;
        rstVals = 32'h45070000;
        wMask = 32'hffff5f00;
        setups = 32'h0;
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        chkOut({8'h00, operatingSetup, mainConverterSetup, decimationWord}, 32'h00000745);
        axr(cra_pkg::OFS_COMMAND, 32'h0, cra_pkg::RESP_OKAY);
        axr(cra_pkg::OFS_IRQ_MASK, 32'h0, cra_pkg::RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            axw(cra_pkg::OFS_COMMAND, {24'h0, 4'h4, i[3:0]}, cra_pkg::RESP_OKAY);
            axr(cra_pkg::OFS_SEQ_STATE, 32'h3, cra_pkg::RESP_OKAY);
            axr(cra_pkg::OFS_TRANSFER, {24'h0, rstVals[i*8 +: 8]}, cra_pkg::RESP_OKAY);
            axr(cra_pkg::OFS_TRANSFER, 32'h0, cra_pkg::RESP_SLVERR);
        end
        for (int i = 1; i < 4; i++) begin
            v = xs();
            axw(cra_pkg::OFS_COMMAND, {28'h0, i[3:0]}, cra_pkg::RESP_OKAY);
            axw(cra_pkg::OFS_TRANSFER, v, cra_pkg::RESP_OKAY);
            axw(cra_pkg::OFS_TRANSFER, v, cra_pkg::RESP_SLVERR);
            setups[i*8 +: 8] = v[7:0] & wMask[i*8 +: 8];
            axw(cra_pkg::OFS_COMMAND, {24'h0, 4'h4, i[3:0]}, cra_pkg::RESP_OKAY);
            axr(cra_pkg::OFS_TRANSFER, {24'h0, setups[i*8 +: 8]}, cra_pkg::RESP_OKAY);
        end
        chkOut({8'h00, operatingSetup, mainConverterSetup, decimationWord},
               {8'h00, setups[15:8], setups[23:16], setups[31:24]});
        axw(cra_pkg::OFS_COMMAND, 32'hc1, cra_pkg::RESP_OKAY);
        axr(cra_pkg::OFS_TRANSFER, 32'h0, cra_pkg::RESP_SLVERR);
        axw(cra_pkg::OFS_COMMAND, 32'h41, cra_pkg::RESP_OKAY);
        axw(cra_pkg::OFS_TRANSFER, 32'h0, cra_pkg::RESP_SLVERR);
        chkOut({24'h0, operatingSetup}, {24'h0, setups[15:8]});
        // Byte lane zero off: command dropped, open read stays
        s_axi_wstrb <= 4'he;
        axw(cra_pkg::OFS_COMMAND, 32'h03, cra_pkg::RESP_OKAY);
        axr(cra_pkg::OFS_SEQ_STATE, 32'h3, cra_pkg::RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        axr(8'h14, 32'h0, cra_pkg::RESP_SLVERR);
        axw(8'h14, 32'h0, cra_pkg::RESP_SLVERR);
        v = xs();
        want <= v[6:0] | 7'h40;
        s = {v[6] | 1'b1, v[5:3], v[2:1], 1'b0, v[0]};
        repeat (8) @(posedge mclk);
        axw(cra_pkg::OFS_COMMAND, 32'h40, cra_pkg::RESP_OKAY);
        axr(cra_pkg::OFS_TRANSFER, {24'h0, s}, cra_pkg::RESP_OKAY);
        axr(cra_pkg::OFS_IRQ_STATUS, {24'h0, s}, cra_pkg::RESP_OKAY);
        chkOut({31'h0, irq}, 32'h0);
        axw(cra_pkg::OFS_IRQ_MASK, 32'h80, cra_pkg::RESP_OKAY);
        repeat (2) @(posedge mclk);
        chkOut({31'h0, irq}, 32'h1);
        want <= 7'h00;
        repeat (8) @(posedge mclk);
        axw(cra_pkg::OFS_IRQ_STATUS, 32'hff, cra_pkg::RESP_OKAY);
        repeat (2) @(posedge mclk);
        chkOut({31'h0, irq}, 32'h0);
        axr(cra_pkg::OFS_IRQ_STATUS, 32'h0, cra_pkg::RESP_OKAY);
        axr(cra_pkg::OFS_IRQ_MASK, 32'h80, cra_pkg::RESP_OKAY);
        repeat (2) @(posedge mclk);
        conclude();
    end
endmodule : tb
